// [pkg/pts_pkg.sv]
// Shared constants for the programmable time switch.
package pts_pkg;
    localparam int CLK_HZ        = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINE_HZ       = 60;
    localparam int CYC_PER_LINE  = CLK_HZ / LINE_HZ;
    localparam int N_STEPS       = 6;
    localparam int N_SKIPS       = 5;

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_STAGE  = 8'h08;
    localparam logic [7:0] OFF_TIME   = 8'h0c;
    localparam logic [7:0] OFF_DATE   = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_REVIEW = 8'h18;

    localparam int CMD_COMMIT_BIT = 4;
    localparam int CMD_KEY_BIT    = 8;
    localparam int CMD_CLR_BIT    = 9;

    localparam logic [3:0] TGT_TIME  = 4'h0;
    localparam logic [3:0] TGT_DATE  = 4'h1;
    localparam logic [3:0] TGT_STEP0 = 4'h2;
    localparam logic [3:0] TGT_SKIP0 = 4'h8;

    localparam int ENT_VALID_BIT = 31;
    localparam int STEP_ON_BIT   = 30;
    localparam int STEP_DAYS_LSB = 16;

    localparam logic [4:0] DST_HOUR        = 5'h02;
    localparam logic [3:0] DST_SPRING_MON  = 4'h3;
    localparam logic [4:0] DST_SPRING_LO   = 5'h08;
    localparam logic [4:0] DST_SPRING_HI   = 5'h0e;
    localparam logic [3:0] DST_FALL_MON    = 4'hb;
    localparam logic [4:0] DST_FALL_HI     = 5'h07;
    localparam logic [3:0] SKIP_MAX_MONTHS = 4'h6;

    localparam logic [6:0] RST_YEAR = 7'h00;
    localparam logic [3:0] RST_MON  = 4'h1;
    localparam logic [4:0] RST_DAY  = 5'h01;
    localparam logic [2:0] RST_WDAY = 3'h6;
endpackage

// [rtl/pts_tick.sv]
// Seconds timebase locked to the power line with a free-running backup divider.
`timescale 1ns/10ps
module pts_tick #(
    parameter int LINE_DIV = pts_pkg::CYC_PER_LINE,
    parameter int LINE_HZ  = pts_pkg::LINE_HZ
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic line_pulse_in,
    input  wire logic line_ok_in,
    output logic      sec_tick_out
);
    localparam int DW = $clog2(LINE_DIV + 1);

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          s3;
        logic [DW-1:0] div;
        logic [6:0]    cyc;
        logic          tick;
    } pts_tick_t;

    pts_tick_t st;
    pts_tick_t next_st;

    // The cycle count is shared by both sources, so a changeover keeps the phase of the second.
    always_comb begin
        logic adv;
        adv = 1'b0;
        next_st = st;
        next_st.s1 = line_pulse_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.tick = 1'b0;
        if (line_ok_in) begin
            next_st.div = '0;
            adv = st.s2 & ~st.s3;
        end else if (st.div == DW'(LINE_DIV - 1)) begin
            next_st.div = '0;
            adv = 1'b1;
        end else begin
            next_st.div = st.div + DW'(1);
        end
        if (adv) begin
            if (st.cyc == 7'(LINE_HZ - 1)) begin
                next_st.cyc = 7'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.cyc = st.cyc + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sec_tick_out = st.tick;
endmodule

// [rtl/pts_top.sv]
// Programmable time switch: clock, calendar, program steps, skip plans and APB registers.
// Overview of operation
// - A step holds hour, minute, weekday mask and an on or off command.
// - A matching step changes the output only as the seconds count reaches zero.
// - Six independent program steps are stored and executed.
// - Five skip plans, each dated by month and day, usable up to a year ahead.
// - A skip plan has start and end dates; output is off between them.
// - Skip plans from one day up to six months are accepted.
// - A plan whose end precedes its start wraps across the new year.
// - A one-day skip may be entered any time before its day.
// - A one-day skip clears itself once its day has passed.
// - Skip plans may be entered into any slot in any order.
// - Reviewing plans reads slot contents and never disturbs the output.
// - Daylight saving changeovers happen automatically at the fixed hour DST_HOUR, 2:00.
// - A pin or a control bit can inhibit the automatic changeover.
// - Data is staged, readable and editable before commit; commits touch one entry.
// - On line failure a backup timebase keeps time and program running.
// - A wiped program raises a loss flag held until cleared from the keypad.
// - On backup power the display blanks and the output is held off.
// - Display shows time, weekday, date, relay state, and am or pm in 12-hour mode.
// - One key press toggles normal and alternate seconds display.
// - The timebase follows line cycles; changeover does not shift kept time.
// - Time, date, weekday and program are settable, time to one second.
`timescale 1ns/10ps
module pts_top #(
    parameter int N_STEPS  = pts_pkg::N_STEPS,
    parameter int N_SKIPS  = pts_pkg::N_SKIPS,
    parameter int LINE_DIV = pts_pkg::CYC_PER_LINE
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        line_pulse_in,
    input  wire logic        line_ok_in,
    input  wire logic        store_lost_in,
    input  wire logic        dst_inhibit_in,
    output logic             relay_out,
    output logic             disp_blank_out,
    output logic             disp_alt_out,
    output logic      [4:0]  disp_hour_out,
    output logic             disp_pm_out,
    output logic             disp_ampm_out,
    output logic             loss_led_out
);
    typedef struct packed {
        logic                       ok_s1;
        logic                       ok_s2;
        logic                       lost_s1;
        logic                       lost_s2;
        logic                       inh_s1;
        logic                       inh_s2;
        logic                       fmt12;
        logic                       dst_en;
        logic [31:0]                stage;
        logic [3:0]                 review_sel;
        logic                       alt_view;
        logic [5:0]                 ss;
        logic [5:0]                 mm;
        logic [4:0]                 hh;
        logic [2:0]                 wday;
        logic [4:0]                 day;
        logic [3:0]                 mon;
        logic [6:0]                 year;
        logic [N_STEPS-1:0][31:0]   steps;
        logic [N_SKIPS-1:0][31:0]   skips;
        logic                       relay_cmd;
        logic                       relay;
        logic                       dst_active;
        logic                       prog_loss;
        logic                       rejected;
        logic                       blank;
        logic [4:0]                 hour_disp;
        logic                       pm;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
    } pts_state_t;

    pts_state_t  st;
    pts_state_t  next_st;
    logic        sec_tick;
    logic        setup;
    logic        bus_wr;
    logic        cmd_wr;
    logic        commit;
    logic        skip_now;
    logic        mapped;
    logic [31:0] rd_data;

    pts_tick #(
        .LINE_DIV (LINE_DIV),
        .LINE_HZ  (pts_pkg::LINE_HZ)
    ) i_pts_tick (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .line_pulse_in (line_pulse_in),
        .line_ok_in    (st.ok_s2),
        .sec_tick_out  (sec_tick)
    );

    function automatic logic [4:0] days_in(input logic [3:0] mon, input logic [6:0] year);
        unique case (mon)
            4'h2: days_in = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
            default: days_in = 5'h1f;
        endcase
    endfunction

    // Plans carry month and day only, so a plan whose end sorts before its start wraps the year.
    function automatic logic skip_covers(input logic [31:0] e, input logic [8:0] today);
        logic [8:0] s;
        logic [8:0] f;
        s = {e[27:24], e[20:16]};
        f = {e[11:8], e[4:0]};
        if (!e[pts_pkg::ENT_VALID_BIT]) begin
            skip_covers = 1'b0;
        end else if (s <= f) begin
            skip_covers = (today >= s) && (today <= f);
        end else begin
            skip_covers = (today >= s) || (today <= f);
        end
    endfunction

    function automatic logic [31:0] entry(input pts_state_t s, input logic [3:0] sel);
        entry = 32'h0;
        for (int i = 0; i < N_STEPS; i++) begin
            if (sel == pts_pkg::TGT_STEP0 + 4'(i)) begin
                entry = s.steps[i];
            end
        end
        for (int i = 0; i < N_SKIPS; i++) begin
            if (sel == pts_pkg::TGT_SKIP0 + 4'(i)) begin
                entry = s.skips[i];
            end
        end
    endfunction

    assign setup  = psel_in & ~penable_in;
    assign bus_wr = psel_in & penable_in & st.pready & pwrite_in;
    assign cmd_wr = bus_wr && paddr_in == pts_pkg::OFF_CMD;
    assign commit = cmd_wr & pwdata_in[pts_pkg::CMD_COMMIT_BIT];

    always_comb begin
        skip_now = 1'b0;
        for (int i = 0; i < N_SKIPS; i++) begin
            skip_now = skip_now | skip_covers(st.skips[i], {st.mon, st.day});
        end
    end

    always_comb begin
        rd_data = 32'h0;
        mapped  = 1'b1;
        unique case (paddr_in)
            pts_pkg::OFF_CTRL:   rd_data = {30'h0, st.dst_en, st.fmt12};
            pts_pkg::OFF_CMD:    rd_data = 32'h0;
            pts_pkg::OFF_STAGE:  rd_data = st.stage;
            pts_pkg::OFF_TIME:   rd_data = {5'h0, st.wday, 3'h0, st.hh, 2'h0, st.mm, 2'h0, st.ss};
            pts_pkg::OFF_DATE:   rd_data = {9'h0, st.year, 4'h0, st.mon, 3'h0, st.day};
            pts_pkg::OFF_STATUS: rd_data = {25'h0, st.rejected, st.alt_view, skip_now,
                                            st.dst_active, st.prog_loss, ~st.ok_s2, st.relay};
            pts_pkg::OFF_REVIEW: rd_data = entry(st, st.review_sel);
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        logic       new_min;
        logic       new_day;
        logic [3:0] tgt;
        logic [3:0] span;
        new_min = 1'b0;
        new_day = 1'b0;
        tgt     = pwdata_in[3:0];
        span    = 4'h0;
        next_st = st;
        next_st.ok_s1   = line_ok_in;
        next_st.ok_s2   = st.ok_s1;
        next_st.lost_s1 = store_lost_in;
        next_st.lost_s2 = st.lost_s1;
        next_st.inh_s1  = dst_inhibit_in;
        next_st.inh_s2  = st.inh_s1;
        if (sec_tick) begin
            if (st.ss == 6'h3b) begin
                next_st.ss = 6'h00;
                new_min = 1'b1;
                if (st.mm == 6'h3b) begin
                    next_st.mm = 6'h00;
                    if (st.hh == 5'h17) begin
                        next_st.hh = 5'h00;
                        new_day = 1'b1;
                    end else begin
                        next_st.hh = st.hh + 5'h01;
                    end
                end else begin
                    next_st.mm = st.mm + 6'h01;
                end
            end else begin
                next_st.ss = st.ss + 6'h01;
            end
        end
        if (new_day) begin
            next_st.wday = (st.wday == 3'h6) ? 3'h0 : st.wday + 3'h1;
            if (st.day == days_in(st.mon, st.year)) begin
                next_st.day = 5'h01;
                if (st.mon == 4'hc) begin
                    next_st.mon  = 4'h1;
                    next_st.year = (st.year == 7'h63) ? 7'h00 : st.year + 7'h01;
                end else begin
                    next_st.mon = st.mon + 4'h1;
                end
            end else begin
                next_st.day = st.day + 5'h01;
            end
            for (int i = 0; i < N_SKIPS; i++) begin
                if (st.skips[i][27:16] == st.skips[i][11:0] &&
                    st.skips[i][27:16] == {st.mon, 3'h0, st.day}) begin
                    next_st.skips[i][pts_pkg::ENT_VALID_BIT] = 1'b0;
                end
            end
        end
        if (new_min && st.dst_en && !st.inh_s2 && next_st.hh == pts_pkg::DST_HOUR &&
            next_st.mm == 6'h00 && next_st.wday == 3'h0) begin
            if (!st.dst_active && next_st.mon == pts_pkg::DST_SPRING_MON &&
                next_st.day >= pts_pkg::DST_SPRING_LO && next_st.day <= pts_pkg::DST_SPRING_HI) begin
                next_st.hh = pts_pkg::DST_HOUR + 5'h01;
                next_st.dst_active = 1'b1;
            end else if (st.dst_active && next_st.mon == pts_pkg::DST_FALL_MON &&
                         next_st.day <= pts_pkg::DST_FALL_HI) begin
                next_st.hh = pts_pkg::DST_HOUR - 5'h01;
                next_st.dst_active = 1'b0;
            end
        end
        if (new_min && !(commit && tgt == pts_pkg::TGT_TIME)) begin
            for (int i = 0; i < N_STEPS; i++) begin
                if (st.steps[i][pts_pkg::ENT_VALID_BIT] &&
                    st.steps[i][pts_pkg::STEP_DAYS_LSB + int'(next_st.wday)] &&
                    st.steps[i][12:8] == next_st.hh && st.steps[i][5:0] == next_st.mm) begin
                    next_st.relay_cmd = st.steps[i][pts_pkg::STEP_ON_BIT];
                end
            end
        end
        if (bus_wr && paddr_in == pts_pkg::OFF_CTRL) begin
            next_st.fmt12  = pwdata_in[0];
            next_st.dst_en = pwdata_in[1];
        end
        if (bus_wr && paddr_in == pts_pkg::OFF_STAGE) begin
            next_st.stage = pwdata_in;
        end
        if (bus_wr && paddr_in == pts_pkg::OFF_REVIEW) begin
            next_st.review_sel = pwdata_in[3:0];
        end
        if (cmd_wr && pwdata_in[pts_pkg::CMD_KEY_BIT]) begin
            next_st.alt_view = ~st.alt_view;
        end
        if (commit) begin
            next_st.rejected = 1'b0;
            if (tgt == pts_pkg::TGT_TIME) begin
                if (st.stage[20:16] < 5'h18 && st.stage[13:8] < 6'h3c &&
                    st.stage[5:0] < 6'h3c && st.stage[26:24] < 3'h7) begin
                    next_st.ss   = st.stage[5:0];
                    next_st.mm   = st.stage[13:8];
                    next_st.hh   = st.stage[20:16];
                    next_st.wday = st.stage[26:24];
                end else begin
                    next_st.rejected = 1'b1;
                end
            end else if (tgt == pts_pkg::TGT_DATE) begin
                if (st.stage[11:8] >= 4'h1 && st.stage[11:8] <= 4'hc && st.stage[4:0] >= 5'h01 &&
                    st.stage[22:16] <= 7'h63) begin
                    next_st.day  = st.stage[4:0];
                    next_st.mon  = st.stage[11:8];
                    next_st.year = st.stage[22:16];
                end else begin
                    next_st.rejected = 1'b1;
                end
            end else if (tgt >= pts_pkg::TGT_SKIP0) begin
                span = (st.stage[11:8] > st.stage[27:24] || st.stage[11:0] >= st.stage[27:16])
                    ? st.stage[11:8] - st.stage[27:24] : st.stage[11:8] + 4'hc - st.stage[27:24];
                if (span > pts_pkg::SKIP_MAX_MONTHS || (span == pts_pkg::SKIP_MAX_MONTHS &&
                    st.stage[4:0] > st.stage[20:16])) begin
                    next_st.rejected = 1'b1;
                end
            end
            for (int i = 0; i < N_STEPS; i++) begin
                if (tgt == pts_pkg::TGT_STEP0 + 4'(i)) begin
                    next_st.steps[i] = st.stage;
                end
            end
            for (int i = 0; i < N_SKIPS; i++) begin
                if (tgt == pts_pkg::TGT_SKIP0 + 4'(i) && !next_st.rejected) begin
                    next_st.skips[i] = st.stage;
                end
            end
        end
        // A loss seen in the same cycle as a keypad clear keeps the flag set.
        if (cmd_wr && pwdata_in[pts_pkg::CMD_CLR_BIT]) begin
            next_st.prog_loss = 1'b0;
        end
        if (st.lost_s2) begin
            next_st.steps     = '0;
            next_st.skips     = '0;
            next_st.relay_cmd = 1'b0;
            next_st.prog_loss = 1'b1;
        end
        next_st.relay = st.relay_cmd & ~skip_now & st.ok_s2;
        next_st.blank = ~st.ok_s2;
        next_st.pm    = st.hh >= 5'h0c;
        if (st.fmt12 && st.hh == 5'h00) begin
            next_st.hour_disp = 5'h0c;
        end else if (st.fmt12 && st.hh > 5'h0c) begin
            next_st.hour_disp = st.hh - 5'h0c;
        end else begin
            next_st.hour_disp = st.hh;
        end
        next_st.pready  = setup;
        next_st.pslverr = setup & ~mapped;
        if (setup) begin
            next_st.prdata = pwrite_in ? 32'h0 : rd_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st      <= '0;
            st.year <= pts_pkg::RST_YEAR;
            st.mon  <= pts_pkg::RST_MON;
            st.day  <= pts_pkg::RST_DAY;
            st.wday <= pts_pkg::RST_WDAY;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out     = st.prdata;
    assign pready_out     = st.pready;
    assign pslverr_out    = st.pslverr;
    assign relay_out      = st.relay;
    assign disp_blank_out = st.blank;
    assign disp_alt_out   = st.alt_view;
    assign disp_hour_out  = st.hour_disp;
    assign disp_pm_out    = st.pm;
    assign disp_ampm_out  = st.fmt12;
    assign loss_led_out   = st.prog_loss;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    chk_backup_relay_off: assert property (!st.ok_s2 [*2] |-> !relay_out)
        else $error("relay active on backup");
    chk_backup_blank: assert property (!st.ok_s2 |=> disp_blank_out)
        else $error("display not blank on backup");
    chk_step_zero_sec: assert property ($changed(st.relay_cmd) && !$past(st.lost_s2)
        |-> st.ss == 6'h00)
        else $error("step took effect off second zero");
    chk_skip_forces_off: assert property (skip_now |=> !relay_out)
        else $error("relay on during skip plan");
    chk_loss_sticky: assert property (st.prog_loss && !cmd_wr |=> st.prog_loss)
        else $error("loss flag dropped without clear");
    chk_loss_wipes: assert property (st.lost_s2 |=> st.prog_loss && st.steps == '0)
        else $error("program not wiped on loss");
    chk_key_toggle: assert property (cmd_wr && pwdata_in[pts_pkg::CMD_KEY_BIT]
        |=> st.alt_view != $past(st.alt_view))
        else $error("key did not toggle view");
    chk_sec_count: assert property (sec_tick && !commit && st.ss != 6'h3b
        |=> st.ss == $past(st.ss) + 6'h01)
        else $error("seconds did not advance");
    chk_review_idle: assert property (bus_wr && paddr_in == pts_pkg::OFF_REVIEW
        && !skip_now && !st.lost_s2 |=> st.relay_cmd == $past(st.relay_cmd) || st.ss == 6'h00)
        else $error("review disturbed output");
    chk_apb_ready: assert property (setup |=> pready_out ##1 !pready_out)
        else $error("apb ready timing wrong");
endmodule

// [sim/pts_line_model.sv]
// Power line model: line cycle wave and line-present flag.
`timescale 1ns/10ps
module pts_line_model #(
    parameter int HALF = 4
) (
    input  wire logic clk_in,
    input  wire logic fail_in,
    output logic      line_pulse_out,
    output logic      line_ok_out
);
    int cnt;
    initial begin
        cnt = 0;
        line_pulse_out = 1'b0;
        line_ok_out = 1'b1;
    end
    // A failed line carries no wave, so the wave is held low while down.
    always @(posedge clk_in) begin
        line_ok_out <= !fail_in;
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (fail_in)
            line_pulse_out <= 1'b0;
        else if (cnt == HALF - 1)
            line_pulse_out <= !line_pulse_out;
    end
endmodule

// [sim/programmable_time_switch_tb_top.sv]
// Self-checking testbench for the programmable time switch.
`timescale 1ns/10ps
module programmable_time_switch_tb_top;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  pa = 0;
    logic [31:0] pwd = 0, prd, rv;
    logic        prdy, perr, re, lp, lok, lost = 0, fail = 0, inh = 0;
    logic        relay, blank, alt, pm, ampm, led;
    logic [4:0]  hr;
    int          mismatches = 0, cmp_count = 0;
    always #20 clk = ~clk;
    pts_line_model i_pts_line_model (.clk_in(clk), .fail_in(fail),
        .line_pulse_out(lp), .line_ok_out(lok));
    pts_top #(.LINE_DIV(4)) i_pts_top (.clk_in(clk), .reset_in(rst),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
        .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .line_pulse_in(lp), .line_ok_in(lok),
        .store_lost_in(lost), .dst_inhibit_in(inh), .relay_out(relay),
        .disp_blank_out(blank), .disp_alt_out(alt), .disp_hour_out(hr),
        .disp_pm_out(pm), .disp_ampm_out(ampm), .loss_led_out(led));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rv = prd;
        re = perr;
        psel <= 0; pen <= 0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wait_relay(input logic v);
        int n;
        n = 0;
        while (relay !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        apb(0, pts_pkg::OFF_TIME, 0);
        chk(rv, 32'h06000000);
        apb(0, pts_pkg::OFF_DATE, 0);
        chk(rv, 32'h00000101);
        apb(0, 8'h40, 0);
        chk(re, 1);
        chk(rv, 0);
        $display("test reset done");
        apb(1, pts_pkg::OFF_STAGE, 32'h0600003b);
        apb(0, pts_pkg::OFF_STAGE, 0);
        chk(rv, 32'h0600003b);
        apb(1, pts_pkg::OFF_CMD, 32'h10);
        apb(0, pts_pkg::OFF_TIME, 0);
        chk(rv & 32'hffffff00, 32'h06000000);
        apb(1, pts_pkg::OFF_STAGE, 32'hc0400001);
        apb(1, pts_pkg::OFF_CMD, 32'h12);
        // A later step on another weekday must not win this minute.
        apb(1, pts_pkg::OFF_STAGE, 32'h80010001);
        apb(1, pts_pkg::OFF_CMD, 32'h13);
        chk(relay, 0);
        wait_relay(1);
        chk(relay, 1);
        apb(0, pts_pkg::OFF_TIME, 0);
        chk(rv & 32'h00003f3f, 32'h00000100);
        $display("test steps done");
        fail <= 1;
        repeat (10) @(posedge clk);
        chk(blank, 1);
        chk(relay, 0);
        apb(0, pts_pkg::OFF_STATUS, 0);
        chk(rv[1], 1);
        fail <= 0;
        repeat (10) @(posedge clk);
        chk(blank, 0);
        chk(relay, 1);
        $display("test backup done");
        apb(1, pts_pkg::OFF_STAGE, 32'h81010101);
        apb(1, pts_pkg::OFF_CMD, 32'h18);
        apb(0, pts_pkg::OFF_STATUS, 0);
        chk(rv[4], 1);
        chk(relay, 0);
        apb(1, pts_pkg::OFF_REVIEW, 32'h8);
        apb(0, pts_pkg::OFF_REVIEW, 0);
        chk(rv, 32'h81010101);
        chk(relay, 0);
        apb(1, pts_pkg::OFF_STAGE, 32'h81010801);
        apb(1, pts_pkg::OFF_CMD, 32'h19);
        apb(0, pts_pkg::OFF_STATUS, 0);
        chk(rv[6], 1);
        $display("test skips done");
        apb(1, pts_pkg::OFF_CMD, 32'h100);
        repeat (2) @(posedge clk);
        chk(alt, 1);
        apb(1, pts_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk(ampm, 1);
        chk(hr, 12);
        chk(pm, 0);
        lost <= 1;
        repeat (8) @(posedge clk);
        chk(led, 1);
        lost <= 0;
        repeat (8) @(posedge clk);
        chk(led, 1);
        apb(1, pts_pkg::OFF_CMD, 32'h200);
        repeat (2) @(posedge clk);
        chk(led, 0);
        $display("test display done");
        // The time is committed last, so the next second tick is the minute under test.
        apb(1, pts_pkg::OFF_CTRL, 32'h2);
        apb(1, pts_pkg::OFF_STAGE, 32'h00010308);
        apb(1, pts_pkg::OFF_CMD, 32'h11);
        apb(1, pts_pkg::OFF_STAGE, 32'h00013b3b);
        apb(1, pts_pkg::OFF_CMD, 32'h10);
        repeat (500) @(posedge clk);
        apb(0, pts_pkg::OFF_TIME, 0);
        chk(rv & 32'h071f3f00, 32'h00030000);
        inh <= 1;
        apb(1, pts_pkg::OFF_STAGE, 32'h00010b01);
        apb(1, pts_pkg::OFF_CMD, 32'h11);
        apb(1, pts_pkg::OFF_STAGE, 32'h00013b3b);
        apb(1, pts_pkg::OFF_CMD, 32'h10);
        repeat (500) @(posedge clk);
        inh <= 0;
        apb(0, pts_pkg::OFF_TIME, 0);
        chk(rv & 32'h071f3f00, 32'h00020000);
        apb(1, pts_pkg::OFF_CMD, 32'h10);
        repeat (500) @(posedge clk);
        apb(0, pts_pkg::OFF_TIME, 0);
        chk(rv & 32'h071f3f00, 32'h00010000);
        $display("test dst done");
        apb(1, pts_pkg::OFF_STAGE, 32'h8b010b01);
        apb(1, pts_pkg::OFF_CMD, 32'h18);
        apb(0, pts_pkg::OFF_STATUS, 0);
        chk(rv[4], 1);
        apb(1, pts_pkg::OFF_STAGE, 32'h00173b3b);
        apb(1, pts_pkg::OFF_CMD, 32'h10);
        repeat (500) @(posedge clk);
        apb(0, pts_pkg::OFF_REVIEW, 0);
        chk(rv, 32'h0b010b01);
        apb(1, pts_pkg::OFF_STAGE, 32'h8b0f0b01);
        apb(1, pts_pkg::OFF_CMD, 32'h19);
        apb(0, pts_pkg::OFF_STATUS, 0);
        chk(rv & 32'h50, 32'h40);
        apb(1, pts_pkg::OFF_STAGE, 32'h8a14010a);
        apb(1, pts_pkg::OFF_CMD, 32'h19);
        apb(0, pts_pkg::OFF_STATUS, 0);
        chk(rv & 32'h50, 32'h10);
        $display("test plans done");
        results;
    end
    // The tests need under 5000 cycles; a hang is cut off well past that.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results;
    end
endmodule
